// File: verilog/cfb_top.sv
// smbus slave register bank and output gating for a six-output fanout buffer
// assumes open-drain bus wires resolved by the board; all pins asynchronous to clk_sys
// Notes on behaviour
// - byte write: address, command, data, each acked
// - byte read: command, restart, read, one byte, nack
// - byte 1 enables outputs 0,1,2 at 4,2,0
// - byte 2 enables outputs 3,4,5 at 7,6,5
// - byte 5 bit 7 selects amplitude source
// - amplitude code maps 300 mV plus 100 per step
// - byte count register resets to six
// - byte 0 reserved read/write, resets zero
// - byte 3 shows revision and maker codes
// - enable pins active high
// - power-good low disables every output
// - power-good high strobes latched inputs valid
// - output runs only with pin and bit
// - disabled output stops synchronously, held low
// - restart on the third reference falling edge, clean
`timescale 1ns/100ps
`include "cfb_map.svh"
module cfb_top #(
  parameter logic [3:0] REV_CODE = 4'h1,
  // arbitrary neutral maker value
  parameter logic [3:0] MAKER_ID = 4'h5
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic sys_rst,
  // serial bus
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  // board control
  input wire logic [5:0] enable_pins,
  input wire logic power_good_powerdown_n,
  input wire logic reference_clock_in,
  // outputs
  output logic [5:0] clock_out,
  output logic [10:0] amplitude_mv
);
  import cfb_pkg::*;

  typedef struct packed {
    logic [1:0] scl_s;
    logic [1:0] sda_s;
    logic [1:0] ref_s;
    logic [1:0] pg_s;
    logic [11:0] pin_s;
    logic scl_d;
    logic sda_d;
    logic ref_d;
    cfb_state_e state;
    cfb_state_e after_ack;
    logic [3:0] bits;
    cfb_byte_t shreg;
    cfb_byte_t cmd;
    logic rd;
    logic ack_drv;
    logic [5:0] pins_latched;
    cfb_byte_t r0;
    cfb_byte_t r1;
    cfb_byte_t r2;
    cfb_byte_t bc;
    cfb_byte_t r5;
    logic [10:0] amp;
    logic sda_oe;
  } cfb_top_s;
  cfb_top_s st, next_st;

  logic scl, sda, scl_rise, scl_fall, start_c, stop_c, ref_fall;
  logic [5:0] en;
  cfb_byte_t rd_byte;

  assign scl = st.scl_s[1];
  assign sda = st.sda_s[1];
  assign scl_rise = scl & ~st.scl_d;
  assign scl_fall = ~scl & st.scl_d;
  assign start_c = scl & st.scl_d & st.sda_d & ~sda;
  assign stop_c = scl & st.scl_d & ~st.sda_d & sda;
  assign ref_fall = ~st.ref_s[1] & st.ref_d;

  always_comb begin
    rd_byte = 8'h00;
    unique case (st.cmd)
      `CFB_REG_RSVD: rd_byte = st.r0;
      `CFB_REG_OE_LO: rd_byte = st.r1;
      `CFB_REG_OE_HI: rd_byte = st.r2;
      `CFB_REG_ID: rd_byte = {REV_CODE, MAKER_ID};
      `CFB_REG_BC: rd_byte = st.bc;
      `CFB_REG_AMP: rd_byte = st.r5;
      default: rd_byte = 8'h00;
    endcase
  end

  always_comb begin
    next_st = st;
    next_st.scl_s = {st.scl_s[0], scl_in};
    next_st.sda_s = {st.sda_s[0], sda_in};
    next_st.ref_s = {st.ref_s[0], reference_clock_in};
    next_st.pg_s = {st.pg_s[0], power_good_powerdown_n};
    next_st.pin_s = {st.pin_s[5:0], enable_pins};
    next_st.scl_d = scl;
    next_st.sda_d = sda;
    next_st.ref_d = st.ref_s[1];
    // pins are only taken while power-good says they are valid
    if (st.pg_s[1]) begin
      next_st.pins_latched = st.pin_s[11:6];
    end
    if (start_c) begin
      next_st.state = CFB_ADDR;
      next_st.bits = 4'd0;
      next_st.sda_oe = 1'b0;
    end else if (stop_c) begin
      next_st.state = CFB_IDLE;
      next_st.sda_oe = 1'b0;
    end else begin
      unique case (st.state)
        CFB_IDLE: next_st.sda_oe = 1'b0;
        CFB_ADDR, CFB_CMD, CFB_WDATA: begin
          if (scl_rise) begin
            next_st.shreg = {st.shreg[6:0], sda};
            next_st.bits = st.bits + 4'd1;
          end
          if (scl_fall && st.bits == 4'd8) begin
            next_st.bits = 4'd0;
            next_st.sda_oe = 1'b1;
            next_st.state = CFB_ACK;
            if (st.state == CFB_ADDR) begin
              if (st.shreg[7:1] != `CFB_ADDR7) begin
                next_st.sda_oe = 1'b0;
                next_st.state = CFB_IDLE;
              end else begin
                next_st.rd = st.shreg[0];
                next_st.after_ack = st.shreg[0] ? CFB_RDATA : CFB_CMD;
                if (!st.shreg[0]) begin
                  next_st.after_ack = CFB_CMD;
                end
                if (st.state == CFB_ADDR && !st.shreg[0]) begin
                  next_st.after_ack = CFB_CMD;
                end
              end
              if (st.shreg[7:1] == `CFB_ADDR7 && !st.shreg[0]) begin
                next_st.after_ack = CFB_CMD;
              end
            end else if (st.state == CFB_CMD) begin
              next_st.cmd = st.shreg;
              next_st.after_ack = CFB_WDATA;
            end else begin
              next_st.after_ack = CFB_WDATA;
              unique case (st.cmd)
                `CFB_REG_RSVD: next_st.r0 = st.shreg;
                `CFB_REG_OE_LO: next_st.r1 = st.shreg;
                `CFB_REG_OE_HI: next_st.r2 = st.shreg;
                `CFB_REG_BC: next_st.bc = st.shreg;
                `CFB_REG_AMP: next_st.r5 = st.shreg;
                default: ;
              endcase
            end
          end
        end
        CFB_ACK: begin
          if (scl_fall) begin
            next_st.state = st.after_ack;
            next_st.sda_oe = 1'b0;
            if (st.after_ack == CFB_RDATA) begin
              next_st.shreg = rd_byte;
              next_st.sda_oe = ~rd_byte[7];
              next_st.bits = 4'd1;
            end
          end
        end
        CFB_RDATA: begin
          if (scl_fall) begin
            if (st.bits == 4'd8) begin
              next_st.sda_oe = 1'b0;
              next_st.state = CFB_RACK;
            end else begin
              next_st.sda_oe = ~st.shreg[3'd7 - st.bits[2:0]];
              next_st.bits = st.bits + 4'd1;
            end
          end
        end
        CFB_RACK: begin
          // one byte only; a nack or an ack both end the read
          if (scl_fall) begin
            next_st.state = CFB_IDLE;
          end
        end
        // unused state code falls back to idle
        default: begin
          next_st.state = CFB_IDLE;
          next_st.sda_oe = 1'b0;
        end
      endcase
    end
    if (st.r5[`CFB_BIT_AMP_SEL]) begin
      next_st.amp = `CFB_AMP_BASE_MV + `CFB_AMP_STEP_MV * {8'd0, st.r5[`CFB_AMP_HI:`CFB_AMP_LO]};
    end else begin
      next_st.amp = `CFB_AMP_DEF_MV;
    end
  end

  // pin high, register bit high and power good all required
  assign en = {st.r2[`CFB_BIT_OE5], st.r2[`CFB_BIT_OE4], st.r2[`CFB_BIT_OE3],
               st.r1[`CFB_BIT_OE2], st.r1[`CFB_BIT_OE1], st.r1[`CFB_BIT_OE0]}
              & st.pins_latched & {6{st.pg_s[1]}};

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      st <= '0;
      st.state <= CFB_IDLE;
      st.after_ack <= CFB_IDLE;
      st.r0 <= `CFB_RST_RSVD;
      st.r1 <= `CFB_RST_OE_LO;
      st.r2 <= `CFB_RST_OE_HI;
      st.bc <= `CFB_RST_BC;
      st.r5 <= `CFB_RST_AMP;
      st.amp <= `CFB_AMP_DEF_MV;
    end else begin
      st <= next_st;
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < 6; gi++) begin : g_out
      cfb_gate u_gate (
        .clk_sys(clk_sys),
        .sys_rst(sys_rst),
        .ref_clk(st.ref_s[1]),
        .ref_fall(ref_fall),
        .enable(en[gi]),
        .clk_out(clock_out[gi])
      );
    end
  endgenerate

  assign sda_oe = st.sda_oe;
  assign sda_out = 1'b0;
  assign amplitude_mv = st.amp;
endmodule

// File: verilog/cfb_map.svh
// register offsets, reset values, field positions and bus constants
// assumes inclusion by bare name from the package and design files
`ifndef CFB_MAP_SVH
`define CFB_MAP_SVH
`define CFB_ADDR7 7'h6B
`define CFB_REG_RSVD 8'h00
`define CFB_REG_OE_LO 8'h01
`define CFB_REG_OE_HI 8'h02
`define CFB_REG_ID 8'h03
`define CFB_REG_BC 8'h04
`define CFB_REG_AMP 8'h05
`define CFB_RST_RSVD 8'h00
`define CFB_RST_OE_LO 8'h15
`define CFB_RST_OE_HI 8'hE0
`define CFB_RST_BC 8'h06
`define CFB_RST_AMP 8'hD8
`define CFB_BIT_OE0 4
`define CFB_BIT_OE1 2
`define CFB_BIT_OE2 0
`define CFB_BIT_OE3 7
`define CFB_BIT_OE4 6
`define CFB_BIT_OE5 5
`define CFB_BIT_AMP_SEL 7
`define CFB_AMP_HI 6
`define CFB_AMP_LO 4
`define CFB_AMP_BASE_MV 11'd300
`define CFB_AMP_STEP_MV 11'd100
`define CFB_AMP_DEF_MV 11'd700
`define CFB_RESUME_EDGES 3'd2
`endif

// File: verilog/cfb_pkg.sv
// types shared by the fanout control block
// assumes cfb_map.svh on the include path
`include "cfb_map.svh"
package cfb_pkg;
  typedef enum logic [2:0] {
    CFB_IDLE, CFB_ADDR, CFB_CMD, CFB_WDATA, CFB_RDATA, CFB_RACK, CFB_ACK
  } cfb_state_e;
  typedef logic [7:0] cfb_byte_t;
endpackage

// File: verilog/cfb_gate.sv
// glitch-free stop and restart of one buffered clock output
// assumes ref_clk is already synchronised to clk_sys
`timescale 1ns/100ps
`include "cfb_map.svh"
module cfb_gate (
  // clock and reset
  input wire logic clk_sys,
  input wire logic sys_rst,
  // reference and control
  input wire logic ref_clk,
  input wire logic ref_fall,
  input wire logic enable,
  // gated clock
  output logic clk_out
);
  typedef struct packed {
    logic run;
    logic [2:0] wait_cnt;
    logic out;
  } cfb_gate_s;
  cfb_gate_s st, next_st;

  always_comb begin
    next_st = st;
    // state only changes at a falling edge so no pulse is ever cut short
    if (ref_fall) begin
      if (!enable) begin
        next_st.run = 1'b0;
        next_st.wait_cnt = 3'd0;
      end else if (!st.run) begin
        if (st.wait_cnt == `CFB_RESUME_EDGES) begin
          next_st.run = 1'b1;
        end else begin
          next_st.wait_cnt = st.wait_cnt + 3'd1;
        end
      end
    end
    next_st.out = next_st.run & ref_clk;
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end
  assign clk_out = st.out;
endmodule

// File: sim/cfb_host.sv
// host model: byte write and byte read on scl/sda
// assumes sda has a pull-up; sda_rel high releases it
`timescale 1ns/100ps
module cfb_host (
  // clock
  input wire logic clk_sys,
  // bus
  output logic scl = 1'b1,
  output logic sda_rel = 1'b1,
  input wire logic sda,
  // result: three acks, then read byte
  output logic res_valid = 1'b0,
  output logic [10:0] res = 11'h000
);
  // quarter bit of 12 cycles keeps scl low and high above 100 ns
  task automatic wt(input int n);
    repeat (n) @(posedge clk_sys);
  endtask
  task automatic bt(input logic b, output logic r);
    sda_rel <= b;
    wt(12);
    scl <= 1'b1;
    wt(12);
    r = sda;
    wt(12);
    scl <= 1'b0;
    wt(12);
  endtask
  task automatic by(input logic [7:0] d, output logic [7:0] q, output logic a);
    for (int i = 7; i >= 0; i--) bt(d[i], q[i]);
    bt(1'b1, a);
  endtask
  task automatic st();
    sda_rel <= 1'b1;
    wt(12);
    scl <= 1'b1;
    wt(12);
    sda_rel <= 1'b0;
    wt(12);
    scl <= 1'b0;
    wt(12);
  endtask
  task automatic xfer(input logic [6:0] ad, input logic rd, input logic [7:0] c, input logic [7:0] d);
    logic [7:0] q;
    logic [2:0] a;
    logic n;
    st();
    by({ad, 1'b0}, q, a[2]);
    by(c, q, a[1]);
    if (rd) begin
      st();
      by({ad, 1'b1}, q, a[0]);
      // released data, then not-ack
      by(8'hFF, q, n);
    end else begin
      by(d, q, a[0]);
      q = 8'h00;
    end
    sda_rel <= 1'b0;
    wt(12);
    scl <= 1'b1;
    wt(12);
    sda_rel <= 1'b1;
    wt(12);
    res <= {a, q};
    res_valid <= 1'b1;
    wt(1);
    res_valid <= 1'b0;
  endtask
endmodule

// File: sim/cfb_top_asserts.sv
// checker: bus and output gating relations of cfb_top
// assumes bind into cfb_top, ports watched as they are
`timescale 1ns/100ps
module cfb_top_asserts (
  // clock and reset
  input wire logic clk_sys,
  input wire logic sys_rst,
  // serial bus
  input wire logic scl_in,
  input wire logic sda_in,
  input wire logic sda_out,
  input wire logic sda_oe,
  // board control
  input wire logic [5:0] enable_pins,
  input wire logic power_good_powerdown_n,
  input wire logic reference_clock_in,
  // outputs
  input wire logic [5:0] clock_out,
  input wire logic [10:0] amplitude_mv
);
  logic [5:0] pd_cnt;
  logic [5:0] off_cnt;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  // saturating, so a long stop cannot wrap
  always_ff @(posedge clk_sys) begin
    pd_cnt <= (sys_rst | power_good_powerdown_n) ? 6'h00 : pd_cnt + 6'(pd_cnt != 6'h3F);
    off_cnt <= (sys_rst | (|enable_pins)) ? 6'h00 : off_cnt + 6'(off_cnt != 6'h3F);
  end
  AST_SDA_LOW: assert property (sda_out == 1'b0) else $error("sda high");
  AST_ACK_EDGE: assert property ($changed(sda_oe) |-> !scl_in) else $error("sda moved, scl high");
  AST_ACK_HOLD: assert property ($rose(scl_in) |=> $stable(sda_oe) [*8]) else $error("sda unstable");
  AST_AMP_STEP: assert property (amplitude_mv >= 11'h12C && amplitude_mv <= 11'h3E8 &&
    amplitude_mv % 11'h064 == 11'h000) else $error("amplitude off grid");
  AST_PD_STOP: assert property (pd_cnt >= 6'h28 |-> clock_out == 6'h00) else $error("runs in power down");
  AST_PIN_STOP: assert property (off_cnt >= 6'h28 |-> clock_out == 6'h00) else $error("runs, pins low");
  AST_FALL_REF: assert property (|($past(clock_out) & ~clock_out) |-> !reference_clock_in) else $error("stop");
  AST_RISE_REF: assert property (|(clock_out & ~$past(clock_out)) |-> reference_clock_in) else $error("start");
  AST_HIGH_FULL: assert property ($rose(clock_out[0]) |-> clock_out[0] [*6]) else $error("short pulse");
  AST_ACK_STANDS: assert property ($rose(sda_oe) |-> sda_oe [*8]) else $error("sda pull too short");
  cover property ($rose(sda_oe));
  cover property (amplitude_mv == 11'h3E8);
  cover property ($rose(clock_out[5]));
endmodule
bind cfb_top cfb_top_asserts chk_u (.clk_sys(clk_sys), .sys_rst(sys_rst), .scl_in(scl_in), .sda_in(sda_in),
  .sda_out(sda_out), .sda_oe(sda_oe), .enable_pins(enable_pins), .power_good_powerdown_n(power_good_powerdown_n),
  .reference_clock_in(reference_clock_in), .clock_out(clock_out), .amplitude_mv(amplitude_mv));

// File: sim/tb_clock_fanout_smbus_control.sv
// bench: register access, amplitude and output gating of cfb_top
// assumes cfb_host on the bus and a pull-up on sda
`timescale 1ns/100ps
`include "cfb_map.svh"
module tb_clock_fanout_smbus_control;
  import cfb_pkg::*;
  // arbitrary id values, overridden so the readback proves the pass-through
  localparam logic [3:0] REV = 4'h3;
  localparam logic [3:0] MAKER = 4'hA;
  localparam cfb_byte_t RV [7] = '{8'h00, 8'h15, 8'hE0, {REV, MAKER}, 8'h06, 8'hD8, 8'h00};
  logic clk_sys = 1'b0;
  logic sys_rst = 1'b1;
  logic ref_clk = 1'b0;
  logic pg_n = 1'b0;
  logic [5:0] pins = 6'h00;
  logic scl, sda_rel, sda_oe, sda_out, res_valid;
  logic [10:0] res, amp;
  logic [5:0] clk_o;
  logic [10:0] exp_q [$];
  cfb_byte_t v, lo, hi;
  int n_mismatch = 0;
  int n_compared = 0;
  int cyc = 0;
  wire logic sda = sda_rel & ~sda_oe;
  cfb_top #(.REV_CODE(REV), .MAKER_ID(MAKER)) dut_u (.clk_sys(clk_sys), .sys_rst(sys_rst), .scl_in(scl),
    .sda_in(sda), .sda_out(sda_out),
    .sda_oe(sda_oe), .enable_pins(pins), .power_good_powerdown_n(pg_n), .reference_clock_in(ref_clk),
    .clock_out(clk_o), .amplitude_mv(amp));
  cfb_host host_u (.clk_sys(clk_sys), .scl(scl), .sda_rel(sda_rel), .sda(sda), .res_valid(res_valid), .res(res));
  always #5 clk_sys = ~clk_sys;
  always #80 ref_clk = ~ref_clk;
  task automatic chk(input logic ok, input string m);
    n_compared++;
    if (ok !== 1'b1) begin
      n_mismatch++;
      $display("unexpected at %0t: %s", $time, m);
    end
  endtask
  always @(posedge clk_sys) if (res_valid === 1'b1) chk(res === exp_q.pop_front(), "bus result");
  task automatic wr(input cfb_byte_t c, input cfb_byte_t d);
    exp_q.push_back(11'h000);
    host_u.xfer(`CFB_ADDR7, 1'b0, c, d);
  endtask
  task automatic rd(input cfb_byte_t c, input cfb_byte_t e);
    exp_q.push_back({3'b000, e});
    host_u.xfer(`CFB_ADDR7, 1'b1, c, 8'h00);
  endtask
  // outputs seen high over two and a half reference periods after settling
  task automatic run_chk(input logic [5:0] e);
    logic [5:0] seen;
    seen = 6'h00;
    repeat (100) @(posedge clk_sys);
    repeat (40) begin
      @(posedge clk_sys);
      seen |= clk_o;
    end
    chk(seen === e, "run mask");
  endtask
  task automatic print_verdict();
    $display("compared %0d, mismatched %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 90000) begin
      n_mismatch++;
      print_verdict();
    end
  end
  initial begin
    void'($urandom(91));
    repeat (12) @(posedge clk_sys);
    sys_rst <= 1'b0;
    pg_n <= 1'b1;
    pins <= 6'h3F;
    repeat (4) @(posedge clk_sys);
    for (int c = 0; c < 7; c++) rd(8'(c), RV[c]);
    chk(amp === 11'h320, "reset amplitude");
    run_chk(6'h3F);
    exp_q.push_back({3'b111, 8'h00});
    host_u.xfer(7'h2A, 1'b0, `CFB_REG_BC, 8'hAA);
    rd(`CFB_REG_BC, 8'h06);
    for (int c = 0; c < 8; c++) begin
      v = 8'($urandom);
      wr(8'(c), v);
      rd(8'(c), c == 3 ? RV[3] : c > 5 ? 8'h00 : v);
    end
    // last pass clears the source bit with code 7
    for (int k = 0; k < 9; k++) begin
      wr(`CFB_REG_AMP, k < 8 ? 8'(8'h80 | (k << 4)) : 8'h70);
      chk(amp === (k < 8 ? 11'(11'h12C + 11'h064 * k) : 11'h2BC), "amplitude");
    end
    repeat (4) begin
      lo = 8'($urandom);
      hi = 8'($urandom);
      v = 8'($urandom);
      wr(`CFB_REG_OE_LO, lo);
      wr(`CFB_REG_OE_HI, hi);
      pins <= v[5:0];
      run_chk(v[5:0] & {hi[5], hi[6], hi[7], lo[0], lo[2], lo[4]});
    end
    pg_n <= 1'b0;
    run_chk(6'h00);
    pg_n <= 1'b1;
    pins <= 6'h00;
    run_chk(6'h00);
    repeat (2) @(posedge clk_sys);
    print_verdict();
  end
endmodule
